// ==== fbm_regs.svh ====
// Purpose: Command field positions, codes and lengths for the full mono-source block transfers
// Assumes: 32-bit command dwords from the streamer
// Notes: Definitions only
`ifndef FBM_REGS_SVH
`define FBM_REGS_SVH
`define FBM_CLIENT_HI 31
`define FBM_CLIENT_LO 29
`define FBM_CLIENT_2D 3'h2
`define FBM_OPC_HI 28
`define FBM_OPC_LO 22
`define FBM_OPC_INLINE_PAT 7'h74
`define FBM_OPC_MONO_SRC 7'h56
`define FBM_OPC_MONO_SRC_PAT 7'h75
`define FBM_MASK_HI 21
`define FBM_MASK_LO 20
`define FBM_BITPOS_HI 19
`define FBM_BITPOS_LO 17
`define FBM_HSEED_HI 14
`define FBM_HSEED_LO 12
`define FBM_TILE_BIT 11
`define FBM_VSEED_HI 10
`define FBM_VSEED_LO 8
`define FBM_LEN_HI 7
`define FBM_LEN_LO 0
`define FBM_LEN_BIAS 8'h02
`define FBM_LEN_MEM_PAT 8'h07
`define FBM_LEN_INLINE_BASE 8'h06
`define FBM_INL_8BPP 8'h10
`define FBM_INL_16BPP 8'h20
`define FBM_INL_32BPP 8'h40
`define FBM_CLIP_BIT 30
`define FBM_TRANSP_BIT 29
`define FBM_DEPTH_HI 25
`define FBM_DEPTH_LO 24
`define FBM_ROP_HI 23
`define FBM_ROP_LO 16
`define FBM_PITCH_HI 15
`define FBM_PITCH_LO 0
`define FBM_PAT_BASE_HI 28
`define FBM_PAT_BASE_LO 6
`endif

// ==== fbm_pkg.sv ====
// Purpose: Types shared by both ends of the mono-source block transfer link
// Assumes: Nothing beyond the constants header
// Notes: Types only
package fbm_pkg;
	typedef enum logic [1:0] {
		FBM_D8,
		FBM_D565,
		FBM_D1555,
		FBM_D32
	} fbm_depth_t;
	typedef logic signed [15:0] fbm_coord_t;
endpackage

// ==== fbm_link_if.sv ====
// Purpose: Command dword link between streamer and decoder
// Assumes: Single clock, valid/ready handshake
// Notes: No clocking block
`timescale 1ns/10ps
`default_nettype none
interface fbm_link_if (
	input wire logic clk
);
	logic cmd_valid;
	logic cmd_ready;
	logic [31:0] cmd_dword;
	logic cmd_last;
	modport streamer (
		input clk,
		output cmd_valid,
		output cmd_dword,
		output cmd_last,
		input cmd_ready
	);
	modport decoder (
		input clk,
		input cmd_valid,
		input cmd_dword,
		input cmd_last,
		output cmd_ready
	);
endinterface
`default_nettype wire

// ==== fbm_streamer.sv ====
// Purpose: Streamer end: sends the dwords of one command as software stages them
// Assumes: Software writes dwords into an indexed store, then starts the send
// Notes: Registers: 0x00 ctrl (bit0 start), 0x04 status (bit0 busy), 0x40+4n dword n
`timescale 1ns/10ps
`default_nettype none
`include "fbm_regs.svh"
module fbm_streamer
	import fbm_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	fbm_link_if.streamer link,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata
);
	// ------------------------------------------------------------
	// Dword store
	// ------------------------------------------------------------
	logic [31:0] store_reg [0:15];
	logic busy_reg;
	logic [3:0] idx_reg;
	logic [3:0] total_reg;
	logic valid_reg;
	logic [31:0] rdata_reg;
	logic [7:0] len_next;

	// Length field counts dwords beyond the bias; issuer keeps it consistent
	always_comb begin
		len_next = store_reg[0][`FBM_LEN_HI:`FBM_LEN_LO] + `FBM_LEN_BIAS - 8'h01;
	end

	always_ff @(posedge clk) begin
		if (reg_wr && reg_addr[7:6] == 2'h1) begin
			store_reg[reg_addr[5:2]] <= reg_wdata;
		end
	end

	// ------------------------------------------------------------
	// Send sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!resetn) begin
			busy_reg <= 1'b0;
			idx_reg <= 4'h0;
			total_reg <= 4'h0;
			valid_reg <= 1'b0;
		end else if (!busy_reg) begin
			if (reg_wr && reg_addr == 8'h00 && reg_wdata[0]) begin
				busy_reg <= 1'b1;
				valid_reg <= 1'b1;
				idx_reg <= 4'h0;
				// Store holds 16 dwords; every inline pattern command, 24 dwords or more, needs a deeper store
				total_reg <= len_next[3:0];
			end
		end else if (valid_reg && link.cmd_ready) begin
			if (idx_reg == total_reg) begin
				busy_reg <= 1'b0;
				valid_reg <= 1'b0;
			end else begin
				idx_reg <= idx_reg + 4'h1;
			end
		end
	end

	assign link.cmd_valid = valid_reg;
	assign link.cmd_dword = store_reg[idx_reg];
	assign link.cmd_last = (idx_reg == total_reg);

	always_ff @(posedge clk) begin
		if (!resetn) begin
			rdata_reg <= 32'h0;
		end else if (reg_rd) begin
			if (reg_addr == 8'h04) begin
				rdata_reg <= {31'h0, busy_reg};
			end else if (reg_addr[7:6] == 2'h1) begin
				rdata_reg <= store_reg[reg_addr[5:2]];
			end else begin
				rdata_reg <= 32'h0;
			end
		end else begin
			rdata_reg <= 32'h0;
		end
	end
	assign reg_rdata = rdata_reg;
endmodule
`default_nettype wire

// ==== fbm_decoder.sv ====
// Purpose: Decoder end: parses full mono-source commands and selects pixels
// Assumes: Streamer keeps pitch positive, bases aligned, reserved bits zero
// Notes: Pixel stage emits one pixel per clock over the destination rectangle
`timescale 1ns/10ps
`default_nettype none
`include "fbm_regs.svh"
module fbm_decoder
	import fbm_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	fbm_link_if.decoder link,
	input wire logic [15:0] mono_word,
	output logic [31:0] mono_addr,
	output logic [31:0] pat_addr,
	output logic [31:0] dst_base,
	output logic px_valid,
	output logic px_write,
	output logic signed [15:0] px_x,
	output logic signed [15:0] px_y,
	output logic [31:0] px_src_color,
	output logic [2:0] px_pat_col,
	output logic [2:0] px_pat_row,
	output logic [7:0] px_rop,
	output logic [1:0] px_byte_mask,
	output logic [1:0] px_depth,
	output logic [3:0] px_mono_bit,
	output logic signed [15:0] dst_pitch,
	output logic bad_cmd,
	output logic busy
);
	typedef enum logic [1:0] {
		FBM_IDLE,
		FBM_RECV,
		FBM_RUN,
		FBM_SKIP
	} fbm_state_t;

	fbm_state_t state_reg;
	logic [7:0] cnt_reg;
	logic [7:0] need_reg;
	logic is_inline_reg;
	logic [31:0] hdr_reg;
	logic [31:0] setup_reg;
	logic [31:0] tl_reg;
	logic [31:0] br_reg;
	logic [31:0] bg_reg;
	logic [31:0] fg_reg;
	logic [31:0] mono_addr_reg;
	logic [31:0] pat_addr_reg;
	logic [31:0] dst_base_reg;
	logic signed [15:0] x_reg;
	logic signed [15:0] y_reg;
	logic [15:0] mono_idx_reg;
	logic valid_reg;
	logic write_reg;
	logic [31:0] color_reg;
	logic [2:0] pcol_reg;
	logic [2:0] prow_reg;
	logic [3:0] mbit_reg;
	logic bad_reg;
	logic [1:0] mask_reg;
	logic busy_reg;

	// ------------------------------------------------------------
	// Header decode
	// ------------------------------------------------------------
	logic hdr_ok;
	logic hdr_inline;
	logic [7:0] inl_need;
	logic [1:0] depth_in;
	always_comb begin
		depth_in = link.cmd_dword[`FBM_DEPTH_HI:`FBM_DEPTH_LO];
		hdr_inline = link.cmd_dword[`FBM_OPC_HI:`FBM_OPC_LO] == `FBM_OPC_MONO_SRC_PAT;
		hdr_ok = link.cmd_dword[`FBM_CLIENT_HI:`FBM_CLIENT_LO] == `FBM_CLIENT_2D
			&& (hdr_inline || link.cmd_dword[`FBM_OPC_HI:`FBM_OPC_LO] == `FBM_OPC_MONO_SRC);
	end

	// Inline pattern size by depth of the setup dword as it arrives
	always_comb begin
		case (depth_in)
			FBM_D8: inl_need = `FBM_INL_8BPP;
			FBM_D565, FBM_D1555: inl_need = `FBM_INL_16BPP;
			default: inl_need = `FBM_INL_32BPP;
		endcase
	end

	// ------------------------------------------------------------
	// Receive sequencer
	// ------------------------------------------------------------
	logic take;
	assign take = link.cmd_valid && link.cmd_ready;
	assign link.cmd_ready = (state_reg == FBM_IDLE) || (state_reg == FBM_RECV) || (state_reg == FBM_SKIP);

	logic line_end;
	logic rect_end;
	assign line_end = (x_reg + 16'sd1) >= $signed(br_reg[15:0]);
	assign rect_end = line_end && ((y_reg + 16'sd1) >= $signed(br_reg[31:16]));

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_reg <= FBM_IDLE;
			cnt_reg <= 8'h0;
			need_reg <= 8'h0;
			is_inline_reg <= 1'b0;
			bad_reg <= 1'b0;
		end else begin
			case (state_reg)
				FBM_IDLE: begin
					if (take) begin
						cnt_reg <= 8'h1;
						is_inline_reg <= hdr_inline;
						// Total dwords is length plus bias
						need_reg <= link.cmd_dword[`FBM_LEN_HI:`FBM_LEN_LO] + `FBM_LEN_BIAS;
						bad_reg <= !hdr_ok;
						if (link.cmd_last) begin
							state_reg <= FBM_IDLE;
						end else begin
							state_reg <= hdr_ok ? FBM_RECV : FBM_SKIP;
						end
					end
				end
				FBM_RECV: begin
					if (take && cnt_reg == 8'h1 && is_inline_reg
						&& hdr_reg[`FBM_LEN_HI:`FBM_LEN_LO] != `FBM_LEN_INLINE_BASE + inl_need) begin
						bad_reg <= 1'b1;
					end
					if (take) begin
						cnt_reg <= cnt_reg + 8'h1;
						if (cnt_reg + 8'h1 >= need_reg || link.cmd_last) begin
							state_reg <= FBM_RUN;
						end
					end
				end
				FBM_RUN: begin
					if (rect_end) begin
						state_reg <= FBM_IDLE;
					end
				end
				FBM_SKIP: begin
					// Unknown commands are drained to their last dword
					if (take && link.cmd_last) begin
						state_reg <= FBM_IDLE;
					end
				end
				default: state_reg <= FBM_IDLE;
			endcase
		end
	end

	// Operand capture; inline pattern dwords are taken off the link and dropped, not captured here
	always_ff @(posedge clk) begin
		if (!resetn) begin
			hdr_reg <= 32'h0;
			setup_reg <= 32'h0;
			tl_reg <= 32'h0;
			br_reg <= 32'h0;
			dst_base_reg <= 32'h0;
			mono_addr_reg <= 32'h0;
			bg_reg <= 32'h0;
			fg_reg <= 32'h0;
			pat_addr_reg <= 32'h0;
		end else if (take && state_reg == FBM_IDLE) begin
			hdr_reg <= link.cmd_dword;
		end else if (take && state_reg == FBM_RECV) begin
			case (cnt_reg)
				8'h1: setup_reg <= link.cmd_dword;
				8'h2: tl_reg <= link.cmd_dword;
				8'h3: br_reg <= link.cmd_dword;
				8'h4: dst_base_reg <= link.cmd_dword;
				8'h5: mono_addr_reg <= link.cmd_dword;
				8'h6: bg_reg <= link.cmd_dword;
				8'h7: fg_reg <= link.cmd_dword;
				8'h8: begin
					if (!is_inline_reg) begin
						pat_addr_reg <= {3'h0, link.cmd_dword[`FBM_PAT_BASE_HI:`FBM_PAT_BASE_LO], 6'h0};
					end
				end
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Pixel walk
	// ------------------------------------------------------------
	logic signed [15:0] x0;
	assign x0 = $signed(tl_reg[15:0]);
	// Mono line starts word aligned; leftover bits dropped at line end
	always_ff @(posedge clk) begin
		if (!resetn) begin
			x_reg <= 16'sh0;
			y_reg <= 16'sh0;
			mono_idx_reg <= 16'h0;
		end else if (state_reg == FBM_RECV && take && (cnt_reg + 8'h1 >= need_reg || link.cmd_last)) begin
			x_reg <= x0;
			y_reg <= $signed(tl_reg[31:16]);
			mono_idx_reg <= {13'h0, hdr_reg[`FBM_BITPOS_HI:`FBM_BITPOS_LO]};
		end else if (state_reg == FBM_RUN) begin
			if (line_end) begin
				x_reg <= x0;
				y_reg <= y_reg + 16'sh1;
				mono_idx_reg <= {13'h0, hdr_reg[`FBM_BITPOS_HI:`FBM_BITPOS_LO]};
			end else begin
				x_reg <= x_reg + 16'sh1;
				mono_idx_reg <= mono_idx_reg + 16'h1;
			end
		end
	end

	logic mono_bit;
	logic in_clip;
	logic [31:0] fg_w;
	logic [31:0] bg_w;
	assign mono_bit = mono_word[4'hf - mono_idx_reg[3:0]];
	// Clip bounds are the destination rectangle's x span, applied whatever the clip bit; no clip unit is attached
	assign in_clip = (x_reg >= x0) && (x_reg < $signed(br_reg[15:0]));
	always_comb begin
		case (setup_reg[`FBM_DEPTH_HI:`FBM_DEPTH_LO])
			FBM_D8: begin
				fg_w = {24'h0, fg_reg[7:0]};
				bg_w = {24'h0, bg_reg[7:0]};
			end
			FBM_D565, FBM_D1555: begin
				fg_w = {16'h0, fg_reg[15:0]};
				bg_w = {16'h0, bg_reg[15:0]};
			end
			default: begin
				fg_w = fg_reg;
				bg_w = bg_reg;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			valid_reg <= 1'b0;
			write_reg <= 1'b0;
			color_reg <= 32'h0;
			pcol_reg <= 3'h0;
			prow_reg <= 3'h0;
			mbit_reg <= 4'h0;
			mask_reg <= 2'h3;
			busy_reg <= 1'b0;
		end else begin
			busy_reg <= state_reg != FBM_IDLE;
			// Mask matters only at 32 bpp; other depths write all channels
			mask_reg <= (setup_reg[`FBM_DEPTH_HI:`FBM_DEPTH_LO] == FBM_D32) ? hdr_reg[`FBM_MASK_HI:`FBM_MASK_LO] : 2'h3;
			valid_reg <= state_reg == FBM_RUN;
			// One selects foreground, zero background unless transparent
			write_reg <= (state_reg == FBM_RUN) && in_clip && (mono_bit || !setup_reg[`FBM_TRANSP_BIT]);
			color_reg <= mono_bit ? fg_w : bg_w;
			pcol_reg <= x_reg[2:0] + hdr_reg[`FBM_HSEED_HI:`FBM_HSEED_LO];
			prow_reg <= y_reg[2:0] + hdr_reg[`FBM_VSEED_HI:`FBM_VSEED_LO];
			mbit_reg <= mono_idx_reg[3:0];
		end
	end

	assign mono_addr = mono_addr_reg;
	assign pat_addr = pat_addr_reg;
	assign dst_base = dst_base_reg;
	assign px_valid = valid_reg;
	assign px_write = write_reg;
	assign px_x = x_reg;
	assign px_y = y_reg;
	assign px_src_color = color_reg;
	assign px_pat_col = pcol_reg;
	assign px_pat_row = prow_reg;
	assign px_rop = setup_reg[`FBM_ROP_HI:`FBM_ROP_LO];
	assign px_byte_mask = mask_reg;
	assign px_depth = setup_reg[`FBM_DEPTH_HI:`FBM_DEPTH_LO];
	assign px_mono_bit = mbit_reg;
	assign dst_pitch = $signed(setup_reg[`FBM_PITCH_HI:`FBM_PITCH_LO]);
	assign bad_cmd = bad_reg;
	assign busy = busy_reg;
endmodule
`default_nettype wire

// ==== fbm_link_checker.sv ====
// Purpose: Checks the command dword stream between streamer and decoder
// Assumes: Both ends are design code joined by one link
// Notes: Helper counter tracks the dword index within a command
`timescale 1ns/10ps
`default_nettype none
`include "fbm_regs.svh"
module fbm_link_checker (
	input wire logic clk,
	input wire logic resetn,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic [31:0] cmd_dword,
	input wire logic cmd_last
);
	logic tk;
	logic [7:0] cnt_reg;
	logic [7:0] len_reg;
	logic mono_reg;
	logic tile_reg;
	assign tk = cmd_valid && cmd_ready;
	always_ff @(posedge clk) begin
		if (!resetn || (tk && cmd_last)) begin
			cnt_reg <= 8'h00;
		end else if (tk) begin
			cnt_reg <= cnt_reg + 8'h01;
		end
	end
	// Header fields are kept so later dwords can be judged against them
	always_ff @(posedge clk) begin
		if (tk && cnt_reg == 8'h00) begin
			len_reg <= cmd_dword[7:0];
			mono_reg <= cmd_dword[31:22] == {`FBM_CLIENT_2D, `FBM_OPC_MONO_SRC};
			tile_reg <= cmd_dword[`FBM_TILE_BIT];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	property p_hold; cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_dword); endproperty
	a_hold: assert property (p_hold) else $error("dword dropped before taken");
	property p_len; tk && cnt_reg == 8'h00 && cmd_dword[31:22] == {`FBM_CLIENT_2D, `FBM_OPC_MONO_SRC} |-> cmd_dword[7:0] == `FBM_LEN_MEM_PAT; endproperty
	a_len: assert property (p_len) else $error("bad length on mono copy");
	property p_last; tk && cmd_last |-> cnt_reg == len_reg + 8'h01; endproperty
	a_last: assert property (p_last) else $error("last flag off count");
	property p_run; tk && cmd_last && mono_reg |=> !cmd_ready; endproperty
	a_run: assert property (p_run) else $error("ready during walk");
	property p_back; !cmd_ready |-> ##[1:200] cmd_ready; endproperty
	a_back: assert property (p_back) else $error("walk never ends");
	property p_pitch; tk && cnt_reg == 8'h01 && mono_reg |-> !cmd_dword[15]; endproperty
	a_pitch: assert property (p_pitch) else $error("negative pitch sent");
	property p_pat; tk && cnt_reg == 8'h08 && mono_reg |-> cmd_dword[5:0] == 6'h00 && cmd_dword[31:29] == 3'h0; endproperty
	a_pat: assert property (p_pat) else $error("pattern base outside field");
	property p_tile; tk && cnt_reg == 8'h04 && tile_reg |-> cmd_dword[11:0] == 12'h000; endproperty
	a_tile: assert property (p_tile) else $error("tiled base unaligned");
endmodule
`default_nettype wire

// ==== full_blit_mono_source_decode_test.sv ====
// Purpose: Stages mono-source commands and checks decoded pixels
// Assumes: Store at 0x40+4n, start at 0x00, busy at 0x04
// Notes: Rectangles are 3x2 so each walk is short
`timescale 1ns/10ps
`default_nettype none
`include "fbm_regs.svh"
module full_blit_mono_source_decode_test;
	import fbm_pkg::*;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] mono_word = 16'h0000;
	logic [31:0] reg_rdata, mono_addr, pat_addr, dst_base, px_src_color;
	logic px_valid, px_write, bad_cmd, busy;
	logic signed [15:0] px_x, px_y, dst_pitch;
	logic [2:0] px_pat_col, px_pat_row;
	logic [7:0] px_rop;
	logic [1:0] px_byte_mask, px_depth;
	logic [3:0] px_mono_bit;
	int n_mismatch = 0;
	int check_count = 0;
	always #25 clk = ~clk;
	fbm_link_if link (.clk(clk));
	fbm_streamer i_fbm_streamer (.clk(clk), .resetn(resetn), .link(link), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	fbm_decoder i_fbm_decoder (.clk(clk), .resetn(resetn), .link(link), .mono_word(mono_word),
		.mono_addr(mono_addr), .pat_addr(pat_addr), .dst_base(dst_base), .px_valid(px_valid),
		.px_write(px_write), .px_x(px_x), .px_y(px_y), .px_src_color(px_src_color),
		.px_pat_col(px_pat_col), .px_pat_row(px_pat_row), .px_rop(px_rop), .px_byte_mask(px_byte_mask),
		.px_depth(px_depth), .px_mono_bit(px_mono_bit), .dst_pitch(dst_pitch), .bad_cmd(bad_cmd), .busy(busy));
	fbm_link_checker i_fbm_link_checker (.clk(clk), .resetn(resetn), .cmd_valid(link.cmd_valid),
		.cmd_ready(link.cmd_ready), .cmd_dword(link.cmd_dword), .cmd_last(link.cmd_last));
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask
	task automatic wait_idle;
		int k;
		for (k = 0; k < 300 && busy !== 1'b0; k++) @(posedge clk);
		chk(busy, 32'h0);
		if (busy !== 1'b0) print_verdict();
	endtask
	// Walk order assumed row by row, left to right; mono bit 15 minus the bit position is the first pixel of each row
	task automatic run_cmd(input logic [1:0] dep, input logic tr, input logic [2:0] bp, input logic [2:0] hs,
		input logic [2:0] vs, input logic tl);
		logic [31:0] d [9];
		logic [31:0] c;
		logic b;
		int n, k, x, y;
		d[0] = {`FBM_CLIENT_2D, `FBM_OPC_MONO_SRC, 2'h2, bp, 2'h0, hs, tl, vs, `FBM_LEN_MEM_PAT};
		d[1] = {2'h0, tr, 3'h0, dep, 8'hc3, 16'h0040};
		d[2] = {16'h0005, 16'hfffe};
		d[3] = {16'h0007, 16'h0001};
		d[4] = 32'h0001_0000;
		d[5] = 32'h0000_1234;
		d[6] = 32'h89ab_cdef;
		d[7] = 32'h1357_9bdf;
		d[8] = 32'h0000_2040;
		for (k = 0; k < 9; k++) wr(8'h40 + 8'(4 * k), d[k]);
		mono_word <= 16'hb5d3;
		wr(8'h00, 32'h1);
		rd(8'h04, 32'h1);
		n = 0;
		for (k = 0; k < 300 && n < 6; k++) begin
			@(posedge clk);
			#1;
			if (px_valid === 1'b1) begin
				x = -2 + n % 3;
				y = 5 + n / 3;
				b = mono_word[15 - bp - n % 3];
				c = b ? d[7] : d[6];
				c = dep == 2'h0 ? {24'h0, c[7:0]} : dep == 2'h3 ? c : {16'h0, c[15:0]};
				chk(px_write, b | !tr);
				if (b | !tr) chk(px_src_color, c);
				chk(px_pat_col, (x + hs) & 7);
				chk(px_pat_row, (y + vs) & 7);
				n++;
			end
		end
		chk(n, 6);
		if (n != 6) print_verdict();
		chk(px_depth, dep);
		chk(px_rop, 8'hc3);
		chk(px_byte_mask, dep == 2'h3 ? 2'h2 : 2'h3);
		chk(dst_pitch, 16'h0040);
		chk(dst_base, d[4]);
		chk(mono_addr, d[5]);
		chk(pat_addr, d[8]);
		wait_idle();
		$display("mono copy test depth %0d done", dep);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		rd(8'h04, 32'h0);
		wr(8'h44, 32'ha5a5_5a5a);
		rd(8'h44, 32'ha5a5_5a5a);
		rd(8'h20, 32'h0);
		$display("register test done");
		for (int i = 0; i < 4; i++) begin
			run_cmd(2'(i), i[0], 3'(2 * i + 1), 3'(3 * i + 5), 3'(7 - i), i == 3);
		end
		wr(8'h40, {3'h3, `FBM_OPC_MONO_SRC, 14'h0, 8'h00});
		wr(8'h00, 32'h1);
		repeat (20) @(posedge clk);
		#1;
		chk(bad_cmd, 32'h1);
		wait_idle();
		$display("foreign client test done");
		print_verdict();
	end
endmodule
`default_nettype wire
